// file: emb_bus.sv
// External multiplexed address/data bus controller with strobes and port mode
//
// Functional notes
// RL1: Upper write strobe qualifies writes of the high byte lane.
// RL2: Read strobe qualifies read transfers on the 16-bit bus.
// RL3: Address latch strobe falls at the falling bus-clock edge of T1.
// RL4: Address latch strobe rises at the falling bus-clock edge of T3.
// RL5: Address latch strobe stays high while no bus cycle runs.
// RL6: In port mode each shared pin is input or output per direction bit.
// RL7: In expansion mode shared pins carry address then data, tri-stated otherwise.
// RL8: With programming entry high, outside circuit drives shared bit 5 low.
// RL9: Lower write strobe qualifies writes of the low byte lane.
// RL10: Block selects assert for their block's cycle, release in idle.
// RL11: Asynchronous wait sampled at falling bus-clock edge in T2 and TW.
// RL12: Strobes are active low and stay off while address is on the lines.
`timescale 1ns/100ps
`default_nettype none

module emb_bus (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Mode control from on-chip logic
    input  wire logic                        ext_mode_en,
    input  wire logic                        wait_en,
    input  wire logic [emb_pkg::DATA_W-1:0]  expansion_port_direction_reg,
    input  wire logic [emb_pkg::DATA_W-1:0]  port_wdata,
    output logic      [emb_pkg::DATA_W-1:0]  port_rdata,
    // Access requests
    input  wire logic                        req_valid,
    input  wire logic                        req_write,
    input  wire logic [emb_pkg::BE_W-1:0]    req_be,
    input  wire logic [emb_pkg::BLK_W-1:0]   req_block,
    input  wire logic [emb_pkg::DATA_W-1:0]  req_addr,
    input  wire logic [emb_pkg::DATA_W-1:0]  req_wdata,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic      [emb_pkg::DATA_W-1:0]  rsp_rdata,
    // Pins
    output logic                             bus_clock_output,
    output logic                             address_latch_strobe,
    output logic                             read_strobe_n,
    output logic                             upper_write_strobe_n,
    output logic                             lower_write_strobe_n,
    output logic      [emb_pkg::BLK_N-1:0]   block_select_n,
    input  wire logic                        wait_req_n,
    input  wire logic                        prog_mode_entry,
    output logic                             prog_mode_select_b,
    input  wire logic [emb_pkg::DATA_W-1:0]  shared_bus_lines_in,
    output logic      [emb_pkg::DATA_W-1:0]  shared_bus_lines_out,
    output logic      [emb_pkg::DATA_W-1:0]  shared_bus_lines_oe
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    emb_pkg::emb_state_t                   state_q;
    logic                                  phase_q;
    logic                                  busclk_q;
    logic                                  mode_ext_q;
    logic                                  wait_hit_q;
    logic                                  als_q;
    logic                                  rd_n_q;
    logic                                  uws_n_q;
    logic                                  lws_n_q;
    logic [emb_pkg::BLK_N-1:0]             cs_n_q;
    logic [emb_pkg::DATA_W-1:0]            lines_out_q;
    logic [emb_pkg::DATA_W-1:0]            lines_oe_q;
    logic                                  write_q;
    logic [emb_pkg::BE_W-1:0]              be_q;
    logic [emb_pkg::DATA_W-1:0]            wdata_q;
    logic                                  req_ready_q;
    logic                                  rsp_valid_q;
    logic [emb_pkg::DATA_W-1:0]            rsp_rdata_q;
    logic                                  prog_b_q;
    logic                                  rd_tail_q;
    logic [emb_pkg::DATA_W-1:0]            pins_s;
    logic [emb_pkg::SYNC_CTRL-1:0]         ctrl_s;
    logic [emb_pkg::DATA_W-1:0]            port_oe;
    logic                                  rise;
    logic                                  fall;
    logic                                  take;
    logic                                  port_idle;

    // Decode a block number into an active-low one-hot select
    function automatic logic [emb_pkg::BLK_N-1:0] blk_sel_n(
        input logic [emb_pkg::BLK_W-1:0] blk
    );
        logic [emb_pkg::BLK_N-1:0] sel;
        sel      = '0;
        sel[blk] = 1'b1;
        return ~sel;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    emb_sync #(
        .W   (emb_pkg::DATA_W),
        .RST (emb_pkg::LINES_RST)
    ) u_sync_lines (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (shared_bus_lines_in),
        .sync_out (pins_s)
    );

    // Wait and programming entry share one small chain
    emb_sync #(
        .W   (emb_pkg::SYNC_CTRL),
        .RST (emb_pkg::CTRL_SYNC_RST)
    ) u_sync_ctrl (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({prog_mode_entry, wait_req_n}),
        .sync_out (ctrl_s)
    );

    // ------------------------------------------------------------
    // Bus clock divider: each bus state is one high and one low cycle
    // ------------------------------------------------------------
    // Edge with phase_q low starts the low half (falling bus edge)
    assign fall      = ~phase_q;
    assign rise      = phase_q;
    assign take      = rise && (state_q == emb_pkg::emb_st_idle) && mode_ext_q && req_valid;
    assign port_idle = (state_q == emb_pkg::emb_st_idle) && !take;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q  <= emb_pkg::PHASE_RST;
            busclk_q <= emb_pkg::BUSCLK_RST;
        end else begin
            phase_q  <= ~phase_q;
            busclk_q <= phase_q;
        end
    end

    // ------------------------------------------------------------
    // Bus-cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= emb_pkg::emb_st_idle;
        end else if (rise) begin
            case (state_q)
                emb_pkg::emb_st_idle: begin
                    if (take) begin
                        state_q <= emb_pkg::emb_st_t1;
                    end
                end
                emb_pkg::emb_st_t1: begin
                    state_q <= emb_pkg::emb_st_t2;
                end
                emb_pkg::emb_st_t2, emb_pkg::emb_st_tw: begin
                    state_q <= wait_hit_q ? emb_pkg::emb_st_tw : emb_pkg::emb_st_t3;
                end
                default: begin
                    state_q <= emb_pkg::emb_st_idle;
                end
            endcase
        end
    end

    // Mode switches only between cycles, so a cycle never loses its lines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ext_q <= 1'b0;
        end else if (rise && state_q == emb_pkg::emb_st_idle) begin
            mode_ext_q <= ext_mode_en;
        end
    end

    // Wait sampled only at the falling bus edge of T2 and TW
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_hit_q <= 1'b0;
        end else if (fall) begin
            if (state_q == emb_pkg::emb_st_t2 || state_q == emb_pkg::emb_st_tw) begin
                wait_hit_q <= wait_en && !ctrl_s[emb_pkg::CTRL_WAIT];   // see RL11
            end else begin
                wait_hit_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready_q <= 1'b0;
            write_q     <= 1'b0;
            be_q        <= '0;
            wdata_q     <= emb_pkg::LINES_RST;
        end else begin
            req_ready_q <= take;
            if (take) begin
                write_q <= req_write;
                be_q    <= req_be;
                wdata_q <= req_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Address latch strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            als_q <= emb_pkg::ALS_IDLE;
        end else if (state_q == emb_pkg::emb_st_idle) begin
            als_q <= emb_pkg::ALS_IDLE;                                // see RL5
        end else if (fall && state_q == emb_pkg::emb_st_t1) begin
            als_q <= 1'b0;                                            // see RL3
        end else if (fall && state_q == emb_pkg::emb_st_t3) begin
            als_q <= emb_pkg::ALS_IDLE;                                // see RL4
        end
    end

    // ------------------------------------------------------------
    // Read and write strobes, block selects
    // ------------------------------------------------------------
    // Strobes open only once data owns the lines, from T2 to end of T3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_n_q  <= emb_pkg::STROBE_OFF;
            uws_n_q <= emb_pkg::STROBE_OFF;
            lws_n_q <= emb_pkg::STROBE_OFF;
        end else if (rise && state_q == emb_pkg::emb_st_t1) begin
            rd_n_q  <= write_q;                                       // see RL2, RL12
            uws_n_q <= !(write_q && be_q[emb_pkg::BE_UPPER]);         // see RL1
            lws_n_q <= !(write_q && be_q[emb_pkg::BE_LOWER]);         // see RL9
        end else if (rise && state_q == emb_pkg::emb_st_t3) begin
            rd_n_q  <= emb_pkg::STROBE_OFF;                           // see RL12
            uws_n_q <= emb_pkg::STROBE_OFF;
            lws_n_q <= emb_pkg::STROBE_OFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_q <= emb_pkg::BLK_OFF;
        end else if (take) begin
            cs_n_q <= blk_sel_n(req_block);                           // see RL10
        end else if (rise && state_q == emb_pkg::emb_st_t3) begin
            cs_n_q <= emb_pkg::BLK_OFF;                               // see RL10
        end
    end

    // ------------------------------------------------------------
    // Shared lines: port mode or multiplexed address/data
    // ------------------------------------------------------------
    // Direction bit high means input; in port mode bit 5 floats during programming entry
    generate
        for (genvar i = 0; i < emb_pkg::DATA_W; i++) begin : g_port_oe
            if (i == emb_pkg::PROG_BIT) begin : g_prog
                assign port_oe[i] = !expansion_port_direction_reg[i]
                                    && !ctrl_s[emb_pkg::CTRL_PROG];   // see RL8
            end else begin : g_plain
                assign port_oe[i] = !expansion_port_direction_reg[i]; // see RL6
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lines_out_q <= emb_pkg::LINES_RST;
            lines_oe_q  <= '0;
        end else if (port_idle) begin
            lines_out_q <= port_wdata;                                // see RL6
            lines_oe_q  <= mode_ext_q ? '0 : port_oe;
        end else if (take) begin
            lines_out_q <= req_addr;                                  // see RL7
            lines_oe_q  <= '1;
        end else if (rise && state_q == emb_pkg::emb_st_t1) begin
            lines_out_q <= wdata_q;                                   // see RL7
            lines_oe_q  <= {emb_pkg::DATA_W{write_q}};
        end else if (rise && state_q == emb_pkg::emb_st_t3) begin
            lines_oe_q  <= '0;                                        // see RL7
        end
    end

    // ------------------------------------------------------------
    // Read data return and programming pin sample
    // ------------------------------------------------------------
    // Data seen through the synchroniser, so it must hold over the low half of the state before T3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_tail_q   <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= emb_pkg::LINES_RST;
            prog_b_q    <= 1'b0;
        end else begin
            rd_tail_q   <= rise && state_q == emb_pkg::emb_st_t3 && !write_q;
            rsp_valid_q <= rd_tail_q;
            if (rd_tail_q) begin
                rsp_rdata_q <= pins_s;
            end
            prog_b_q <= pins_s[emb_pkg::PROG_BIT];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign port_rdata           = pins_s;
    assign req_ready            = req_ready_q;
    assign rsp_valid            = rsp_valid_q;
    assign rsp_rdata            = rsp_rdata_q;
    assign bus_clock_output     = busclk_q;
    assign address_latch_strobe = als_q;
    assign read_strobe_n        = rd_n_q;
    assign upper_write_strobe_n = uws_n_q;
    assign lower_write_strobe_n = lws_n_q;
    assign block_select_n       = cs_n_q;
    assign prog_mode_select_b   = prog_b_q;
    assign shared_bus_lines_out = lines_out_q;
    assign shared_bus_lines_oe  = lines_oe_q;

endmodule
`default_nettype wire

// file: emb_bus_sva.sv
// Concurrent checks on the multiplexed bus pins of the strobe block
`timescale 1ns/100ps
`default_nettype none

module emb_bus_sva (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       wait_en,
    input wire logic                       req_write,
    input wire logic [emb_pkg::BE_W-1:0]   req_be,
    input wire logic [emb_pkg::BLK_W-1:0]  req_block,
    input wire logic [emb_pkg::DATA_W-1:0] req_addr,
    input wire logic                       req_ready,
    input wire logic                       rsp_valid,
    input wire logic                       address_latch_strobe,
    input wire logic                       read_strobe_n,
    input wire logic                       upper_write_strobe_n,
    input wire logic                       lower_write_strobe_n,
    input wire logic [emb_pkg::BLK_N-1:0]  block_select_n,
    input wire logic                       wait_req_n,
    input wire logic [emb_pkg::DATA_W-1:0] shared_bus_lines_out,
    input wire logic [emb_pkg::DATA_W-1:0] shared_bus_lines_oe
);
    // ------------------------------------------------------------
    // Cycle timing, counted from the take of a request
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_ALS_WINDOW: assert property (req_ready && !wait_en |=>
        (!address_latch_strobe)[*4] ##1 address_latch_strobe) else $error("latch strobe window");
    AST_ALS_IDLE: assert property (block_select_n == 4'hF |-> address_latch_strobe)
        else $error("latch strobe low while idle");
    AST_BLK_SEL: assert property (req_ready && !wait_en |->
        (block_select_n == ~(4'h1 << req_block))[*6] ##1 (block_select_n == 4'hF))
        else $error("block select wrong");
    AST_UPPER: assert property (req_ready && req_write && !wait_en |=> ##1
        (upper_write_strobe_n == !req_be[1])[*4] ##1 upper_write_strobe_n)
        else $error("upper write strobe wrong");
    AST_LOWER: assert property (req_ready && req_write && !wait_en |=> ##1
        (lower_write_strobe_n == !req_be[0])[*4] ##1 lower_write_strobe_n)
        else $error("lower write strobe wrong");
    AST_READ: assert property (req_ready && !req_write && !wait_en |=> ##1
        (!read_strobe_n)[*4] ##1 read_strobe_n) else $error("read strobe wrong");
    // Address phase must never see a strobe, or a latch would grab data
    AST_ADDR_QUIET: assert property (req_ready |->
        (read_strobe_n && upper_write_strobe_n && lower_write_strobe_n)[*2])
        else $error("strobe during address phase");
    AST_ADDR_OUT: assert property (req_ready |-> shared_bus_lines_oe == 16'hFFFF &&
        shared_bus_lines_out == req_addr) else $error("address not driven");
    AST_TURN: assert property (req_ready && !req_write && !wait_en |=> ##1
        shared_bus_lines_oe == 16'h0000 ##5 rsp_valid) else $error("read turnaround wrong");
    AST_WAIT: assert property (req_ready && wait_en && !wait_req_n |=>
        (!address_latch_strobe)[*6]) else $error("wait state not inserted");

    COV_WRITE: cover property (req_ready && req_write);
    COV_READ: cover property (rsp_valid);
    COV_WAIT: cover property (req_ready && wait_en && !wait_req_n);
endmodule

bind emb_bus emb_bus_sva chk (.clk, .rst_n, .wait_en, .req_write, .req_be, .req_block,
    .req_addr, .req_ready, .rsp_valid, .address_latch_strobe, .read_strobe_n,
    .upper_write_strobe_n, .lower_write_strobe_n, .block_select_n, .wait_req_n,
    .shared_bus_lines_out, .shared_bus_lines_oe);
`default_nettype wire

// file: emb_ext_mem.sv
// Behavioural external memory sitting on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none

module emb_ext_mem (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        address_latch_strobe,
    input  wire logic        read_strobe_n,
    input  wire logic        upper_write_strobe_n,
    input  wire logic        lower_write_strobe_n,
    input  wire logic [15:0] bus_out,
    output logic      [15:0] mem_q,
    output logic             wait_req_n
);
    logic [15:0] mem [16];
    logic [3:0]  adr;
    logic [15:0] last;
    logic [3:0]  cnt;

    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        adr = 4'h0;
        last = 16'h0000;
        cnt = 4'h0;
    end

    // Address captured as the latch strobe falls
    always @(negedge address_latch_strobe) adr = bus_out[3:0];

    // Byte lanes written while their strobe is low
    always @(posedge clk) begin
        if (!upper_write_strobe_n) mem[adr][15:8] <= bus_out[15:8];
        if (!lower_write_strobe_n) mem[adr][7:0] <= bus_out[7:0];
        if (!read_strobe_n) last <= mem[adr];
        cnt <= address_latch_strobe ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
    end

    // Released lines show the inverse, so stale data never passes
    assign mem_q = read_strobe_n ? ~last : mem[adr];
    // Slow device holds wait until six cycles into the access
    assign wait_req_n = !(slow && cnt < 4'h6);
endmodule
`default_nettype wire

// file: emb_pkg.sv
// Shared constants and types for the external multiplexed bus strobe block
package emb_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W    = 16;
    localparam int BLK_N     = 4;
    localparam int BLK_W     = 2;
    localparam int BE_W      = 2;
    localparam int SYNC_CTRL = 2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PROG_BIT  = 5;     // Shared line doubling as programming-mode pin
    localparam int BE_UPPER  = 1;
    localparam int BE_LOWER  = 0;
    localparam int CTRL_WAIT = 0;
    localparam int CTRL_PROG = 1;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic              STROBE_OFF  = 1'h1;
    localparam logic              ALS_IDLE    = 1'h1;
    localparam logic [BLK_N-1:0]  BLK_OFF     = 4'hF;
    localparam logic [DATA_W-1:0] LINES_RST   = 16'h0000;
    localparam logic              PHASE_RST   = 1'h0;
    localparam logic              BUSCLK_RST  = 1'h0;
    localparam logic [SYNC_CTRL-1:0] CTRL_SYNC_RST = 2'h1;   // Wait request idle high

    // ------------------------------------------------------------
    // Bus-cycle states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        emb_st_idle = 5'b00001,
        emb_st_t1   = 5'b00010,
        emb_st_t2   = 5'b00100,
        emb_st_tw   = 5'b01000,
        emb_st_t3   = 5'b10000
    } emb_state_t;

endpackage

// file: emb_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module emb_sync #(
    parameter int              W   = 16,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;

    // ------------------------------------------------------------
    // Sampling chain; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Per bit: follow stage three only while it agrees with stage two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= RST;
        end else begin
            out_q <= (s3_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
        end
    end

    assign sync_out = out_q;

endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the multiplexed bus strobe block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic        clk, rst_n, ext_mode_en, wait_en, req_valid, req_write, prog_mode_entry;
    logic        slow, req_ready, rsp_valid, bus_clk, als, rd_n, uw_n, lw_n, wait_n, prog_sel;
    logic [1:0]  req_be, req_block;
    logic [3:0]  bs;
    logic [15:0] dir, port_wdata, port_rdata, req_addr, req_wdata, rsp_rdata;
    logic [15:0] pins_drv, lines_out, lines_oe, lines_in, mem_q, rd;
    int          failures, cmp_count, lat;

    // ------------------------------------------------------------
    // Pin resolution: the driving party wins, else the far side
    // ------------------------------------------------------------
    assign lines_in = (lines_oe & lines_out) | (~lines_oe & (ext_mode_en ? mem_q : pins_drv));

    emb_bus dut (.clk(clk), .rst_n(rst_n), .ext_mode_en(ext_mode_en), .wait_en(wait_en),
        .expansion_port_direction_reg(dir), .port_wdata(port_wdata), .port_rdata(port_rdata),
        .req_valid(req_valid), .req_write(req_write), .req_be(req_be), .req_block(req_block),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_clock_output(bus_clk),
        .address_latch_strobe(als), .read_strobe_n(rd_n), .upper_write_strobe_n(uw_n),
        .lower_write_strobe_n(lw_n), .block_select_n(bs), .wait_req_n(wait_n),
        .prog_mode_entry(prog_mode_entry), .prog_mode_select_b(prog_sel),
        .shared_bus_lines_in(lines_in), .shared_bus_lines_out(lines_out),
        .shared_bus_lines_oe(lines_oe));

    emb_ext_mem mem (.clk(clk), .slow(slow), .address_latch_strobe(als), .read_strobe_n(rd_n),
        .upper_write_strobe_n(uw_n), .lower_write_strobe_n(lw_n), .bus_out(lines_out),
        .mem_q(mem_q), .wait_req_n(wait_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize;
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait ran out
    task automatic give_up;
        failures++;
        summarize;
    endtask

    // One bus cycle; request held until taken, latency counted in cycles
    task automatic do_req(input logic w, input logic [1:0] be, input logic [1:0] blk,
                          input logic [15:0] a, input logic [15:0] wd);
        int n;
        req_write = w;
        req_be = be;
        req_block = blk;
        req_addr = a;
        req_wdata = wd;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 40) give_up;
        end
        check("block select", {12'h000, ~(4'h1 << blk)}, {12'h000, bs});
        req_valid = 1'b0;
        lat = 0;
        while (!w && rsp_valid !== 1'b1) begin
            @(negedge clk);
            lat++;
            if (lat > 60) give_up;
        end
        rd = rsp_rdata;
        n = 0;
        while (bs !== 4'hF) begin
            @(negedge clk);
            n++;
            if (n > 60) give_up;
        end
        repeat (2) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_port;
        repeat (8) @(negedge clk);
        check("port enables", 16'h00FF, lines_oe);
        check("port drive", 16'h00A5, lines_out & 16'h00FF);
        check("port read", 16'h3CA5, port_rdata);
        check("prog select", 16'h0001, {15'h0, prog_sel});
        prog_mode_entry = 1'b1;
        repeat (12) @(negedge clk);
        check("prog float", 16'h00DF, lines_oe);
        check("prog read", 16'h3C85, port_rdata);
        check("prog select", 16'h0000, {15'h0, prog_sel});
        prog_mode_entry = 1'b0;
        dir = 16'h00FF;
        repeat (8) @(negedge clk);
        check("port flip", 16'hFF00, lines_oe);
    endtask

    task automatic t_refuse;
        int seen;
        seen = 0;
        req_valid = 1'b1;
        repeat (20) begin
            @(negedge clk);
            if (req_ready !== 1'b0) seen++;
        end
        req_valid = 1'b0;
        check("port mode take", 16'h0000, seen[15:0]);
    endtask

    task automatic t_expand;
        logic [15:0] exp [3] = '{16'h1234, 16'hAB00, 16'h005A};
        ext_mode_en = 1'b1;
        repeat (6) @(negedge clk);
        check("idle float", 16'h0000, lines_oe);
        do_req(1'b1, 2'h3, 2'h0, 16'h0000, 16'h1234);
        do_req(1'b1, 2'h2, 2'h1, 16'h0001, 16'hABCD);
        do_req(1'b1, 2'h1, 2'h2, 16'h0002, 16'h5A5A);
        for (int i = 0; i < 3; i++) begin
            do_req(1'b0, 2'h3, 2'(i + 1), 16'(i), 16'h0000);
            check("read data", exp[i], rd);
            check("read latency", 16'h0007, lat[15:0]);
        end
    endtask

    task automatic t_wait;
        slow = 1'b1;
        wait_en = 1'b1;
        repeat (6) @(negedge clk);
        do_req(1'b0, 2'h3, 2'h3, 16'h0001, 16'h0000);
        check("wait data", 16'hAB00, rd);
        check("wait stretch", 16'h0001, {15'h0, lat > 7 && lat % 2 == 1});
        wait_en = 1'b0;
        repeat (6) @(negedge clk);
        do_req(1'b0, 2'h3, 2'h0, 16'h0000, 16'h0000);
        check("wait ignored", 16'h0007, lat[15:0]);
        slow = 1'b0;
    endtask

    initial begin
        failures = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        {ext_mode_en, wait_en, req_valid, req_write, prog_mode_entry, slow} = 6'h00;
        {req_be, req_block} = 4'h0;
        {req_addr, req_wdata} = 32'h0000_0000;
        dir = 16'hFF00;
        port_wdata = 16'h00A5;
        pins_drv = 16'h3C00;
        repeat (8) @(negedge clk);
        check("idle latch strobe", 16'h0001, {15'h0, als});
        check("idle strobes", 16'h0007, {13'h0, rd_n, uw_n, lw_n});
        check("idle selects", 16'h000F, {12'h000, bs});
        rst_n = 1'b1;
        t_port;
        t_refuse;
        t_expand;
        t_wait;
        summarize;
    end
endmodule
`default_nettype wire
